/* flash_gate_defs.vh */
// Constants of the flash command gate and fault status block.
`ifndef FLASH_GATE_DEFS_VH
`define FLASH_GATE_DEFS_VH
`define ADR_STATUS 8'h00
`define ADR_CONFIG 8'h04
`define ADR_PROT 8'h08
`define ADR_RSV1 8'h0C
`define ADR_INDEX 8'h10
`define ADR_CCOB 8'h14
`define ADR_FAULT 8'h18
`define ST_COMPLETE 7
`define ST_ACCESS_ERROR_FLAG 5
`define CFG_IGNORE_SINGLE_FAULT 4
`define FLT_DOUBLE 1
`define FLT_SINGLE 0
`define PROT_OPEN 7
`define PROT_HI_DIS 5
`define PROT_LO_DIS 2
`define PROT_RESET 8'hFF
`define PROT_DBL_FAULT 8'h7F
`define CMD_VFY_ALL 8'h01
`define CMD_VFY_BLK 8'h02
`define CMD_VFY_SECT 8'h03
`define CMD_RD_ONCE 8'h04
`define CMD_PGM 8'h06
`define CMD_PGM_ONCE 8'h07
`define CMD_ERS_ALL 8'h08
`define CMD_ERS_BLK 8'h09
`define CMD_ERS_SECT 8'h0A
`define CMD_UNSECURE 8'h0B
`define CMD_VFY_KEY 8'h0C
`define CMD_USR_MARGIN 8'h0D
`define CMD_FLD_MARGIN 8'h0E
`define CMD_VFY_EE 8'h10
`define CMD_PGM_EE 8'h11
`define CMD_ERS_EE 8'h12
`define IDX_CODE 3'h0
`endif

/* flash_cmd_permit.v */
// Mode and security permission check for flash command codes.
`timescale 1ns/100ps
`include "flash_gate_defs.vh"
module flash_cmd_permit (
  input wire [7:0] i_code, // Command code to check.
  input wire i_special, // High in special single-chip mode.
  input wire i_secure, // High when the chip is secured.
  output reg o_ok // High when the code may run.
);
  // Decode the code against the four mode and security corners.
  always @* begin
    case (i_code)
      `CMD_VFY_ALL, `CMD_VFY_BLK: begin
        o_ok = 1'b1;
      end
      `CMD_VFY_SECT, `CMD_RD_ONCE, `CMD_PGM, `CMD_PGM_ONCE, `CMD_ERS_BLK, `CMD_ERS_SECT,
      `CMD_USR_MARGIN, `CMD_VFY_EE, `CMD_PGM_EE, `CMD_ERS_EE: begin
        o_ok = ~(i_secure & i_special);
      end
      `CMD_ERS_ALL, `CMD_UNSECURE: begin
        o_ok = i_special;
      end
      `CMD_VFY_KEY: begin
        o_ok = ~i_special;
      end
      `CMD_FLD_MARGIN: begin
        o_ok = i_special & ~i_secure;
      end
      default: begin
        o_ok = 1'b0;
      end
    endcase
  end
endmodule

/* flash_ccob_mem.v */
// Command object store: eight 16-bit words with byte enables and registered read.
`timescale 1ns/100ps
module flash_ccob_mem (
  input wire i_clk, // Bus clock.
  input wire [2:0] i_addr, // Word index for both ports.
  input wire i_we, // Write strobe.
  input wire [1:0] i_be, // Byte enables, bit 1 is the high byte.
  input wire [15:0] i_wdata, // Write data.
  output reg [15:0] o_rdata // Registered read data.
);
  reg [15:0] mem [0:7];

  // Byte-wise write, and read data taken into a register every cycle.
  always @(posedge i_clk) begin
    if (i_we && i_be[1]) begin
      mem[i_addr][15:8] <= i_wdata[15:8];
    end
    if (i_we && i_be[0]) begin
      mem[i_addr][7:0] <= i_wdata[7:0];
    end
    o_rdata <= mem[i_addr];
  end
endmodule

/* flash_gate.v */
// Flash command gate, fault status, protection and command object registers.
//
// Implementation choice: the Wishbone register port.
`timescale 1ns/100ps
`include "flash_gate_defs.vh"
module flash_gate (
  input wire i_clk, // Bus clock, 250 MHz.
  input wire i_arst_n, // Asynchronous system reset, active low.
  input wire i_wb_cyc, // Wishbone cycle.
  input wire i_wb_stb, // Wishbone strobe.
  input wire i_wb_we, // Wishbone write enable.
  input wire [7:0] i_wb_adr, // Wishbone byte address.
  input wire [3:0] i_wb_sel, // Wishbone byte selects.
  input wire [31:0] i_wb_dat, // Wishbone write data.
  output reg o_wb_ack, // Wishbone acknowledge.
  output reg [31:0] o_wb_dat, // Wishbone read data.
  input wire i_special_mode_in, // Chip in special single-chip mode.
  input wire i_secure_state_in, // Chip secured.
  input wire i_array_read, // One-cycle pulse per flash array read.
  input wire i_ecc_single, // Corrected single-bit fault on this read.
  input wire i_ecc_double, // Double-bit fault on this read.
  input wire i_prot_load, // Pulse when the reset sequence has read the protection byte.
  input wire [7:0] i_prot_byte, // Protection byte read by the reset sequence.
  input wire i_prot_load_dbl, // Double-bit fault on the protection phrase.
  input wire i_exec_done, // Array sequencer finished the running command.
  output reg o_exec_start, // One-cycle pulse starting a permitted command.
  output reg [7:0] o_exec_code, // Code of the running command.
  output reg o_verify_pflash, // Running command checks every program-flash block.
  output reg o_verify_eeprom, // Running command checks every EEPROM block.
  output reg o_busy, // A command is running.
  output reg [7:0] o_prot // Protection byte to the array sequencer.
);
  localparam ST_IDLE = 3'b001;
  localparam ST_WAIT = 3'b010;
  localparam ST_ACK = 3'b100;

  reg [2:0] bus_st_r;
  reg [2:0] bus_st_nxt;
  reg complete_r;
  reg access_error_flag_r;
  reg ignore_single_fault_r;
  reg [2:0] index_r;
  reg [7:0] code_r;
  reg sf_r;
  reg df_r;
  reg rd_q_r;
  reg sgl_q_r;
  reg dbl_q_r;
  reg col_q_r;
  reg [31:0] rdat_nxt;
  wire req;
  wire wr_go;
  wire sel_hi;
  wire sel_lo;
  wire [15:0] ccob_rdata;
  wire ccob_we;
  wire permit_ok;
  wire launch;
  wire set_sf;
  wire set_df;
  wire prot_ok;
  wire [7:0] prot_new;

  assign req = i_wb_cyc & i_wb_stb;
  // A write commits on the edge at which the acknowledge rises.
  assign wr_go = (bus_st_r == ST_WAIT) & req & i_wb_we;
  assign sel_hi = i_wb_sel[1];
  assign sel_lo = i_wb_sel[0];

  // Bus handshake: one wait state, then acknowledge for one cycle.
  always @* begin
    case (bus_st_r)
      ST_IDLE: begin
        bus_st_nxt = req ? ST_WAIT : ST_IDLE;
      end
      ST_WAIT: begin
        bus_st_nxt = req ? ST_ACK : ST_IDLE;
      end
      ST_ACK: begin
        bus_st_nxt = ST_IDLE;
      end
      default: begin
        bus_st_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      bus_st_r <= ST_IDLE;
      o_wb_ack <= 1'b0;
    end else begin
      bus_st_r <= bus_st_nxt;
      o_wb_ack <= (bus_st_nxt == ST_ACK);
    end
  end

  // Command object words; a write to index zero with the high byte selected also fixes the command code.
  assign ccob_we = (i_wb_adr == `ADR_CCOB) & wr_go & complete_r;

  flash_ccob_mem u_ccob (
    .i_clk(i_clk),
    .i_addr(index_r),
    .i_we(ccob_we),
    .i_be(i_wb_sel[1:0]),
    .i_wdata(i_wb_dat[15:0]),
    .o_rdata(ccob_rdata)
  );

  // Mode from the special input, security from the secure input.
  flash_cmd_permit u_permit (
    .i_code(code_r),
    .i_special(i_special_mode_in),
    .i_secure(i_secure_state_in),
    .o_ok(permit_ok)
  );

  // Writing one to the complete flag while idle and error free launches.
  assign launch = (i_wb_adr == `ADR_STATUS) & wr_go & sel_lo & i_wb_dat[`ST_COMPLETE] &
                  complete_r & ~access_error_flag_r;

  // Status, configuration, index and command code registers.
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      complete_r <= 1'b1;
      access_error_flag_r <= 1'b0;
      ignore_single_fault_r <= 1'b0;
      index_r <= 3'h0;
      code_r <= 8'h00;
    end else begin
      if (launch && !permit_ok) begin
        access_error_flag_r <= 1'b1;
      end else if ((i_wb_adr == `ADR_STATUS) && wr_go && sel_lo && i_wb_dat[`ST_ACCESS_ERROR_FLAG]) begin
        access_error_flag_r <= 1'b0;
      end
      if (launch && permit_ok) begin
        complete_r <= 1'b0;
      end else if (!complete_r && i_exec_done) begin
        complete_r <= 1'b1;
      end
      if ((i_wb_adr == `ADR_CONFIG) && wr_go && sel_lo) begin
        ignore_single_fault_r <= i_wb_dat[`CFG_IGNORE_SINGLE_FAULT];
      end
      if ((i_wb_adr == `ADR_INDEX) && wr_go && sel_lo && complete_r) begin
        index_r <= i_wb_dat[2:0];
      end
      if (ccob_we && (index_r == `IDX_CODE) && sel_hi) begin
        code_r <= i_wb_dat[15:8];
      end
    end
  end

  // Start pulse and command outputs toward the array sequencer.
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_exec_start <= 1'b0;
      o_exec_code <= 8'h00;
      o_verify_pflash <= 1'b0;
      o_verify_eeprom <= 1'b0;
      o_busy <= 1'b0;
    end else begin
      o_exec_start <= launch & permit_ok;
      if (launch && permit_ok) begin
        o_exec_code <= code_r;
        o_verify_pflash <= (code_r == `CMD_VFY_ALL);
        o_verify_eeprom <= (code_r == `CMD_VFY_ALL);
        o_busy <= 1'b1;
      end else if (!complete_r && i_exec_done) begin
        o_verify_pflash <= 1'b0;
        o_verify_eeprom <= 1'b0;
        o_busy <= 1'b0;
      end
    end
  end

  // Read events are staged one cycle before the flags take them.
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rd_q_r <= 1'b0;
      sgl_q_r <= 1'b0;
      dbl_q_r <= 1'b0;
      col_q_r <= 1'b0;
    end else begin
      rd_q_r <= i_array_read;
      sgl_q_r <= i_ecc_single;
      dbl_q_r <= i_ecc_double;
      col_q_r <= i_array_read & ~complete_r;
    end
  end

  // A genuine fault is either single or double; a collision raises double, and single too unless single faults are ignored.
  assign set_df = rd_q_r & (dbl_q_r | col_q_r);
  assign set_sf = rd_q_r & ~ignore_single_fault_r & ((sgl_q_r & ~dbl_q_r) | col_q_r);

  // Fault flags: hardware set wins over a write-one clear in the same cycle.
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sf_r <= 1'b0;
      df_r <= 1'b0;
    end else begin
      if (set_df) begin
        df_r <= 1'b1;
      end else if ((i_wb_adr == `ADR_FAULT) && wr_go && sel_lo && i_wb_dat[`FLT_DOUBLE]) begin
        df_r <= 1'b0;
      end
      if (set_sf) begin
        sf_r <= 1'b1;
      end else if ((i_wb_adr == `ADR_FAULT) && wr_go && sel_lo && i_wb_dat[`FLT_SINGLE]) begin
        sf_r <= 1'b0;
      end
    end
  end

  // A write may only keep or grow each protected range and never move the open bit.
  assign prot_new = i_wb_dat[7:0];
  assign prot_ok = (prot_new[`PROT_OPEN] == o_prot[`PROT_OPEN]) &
                   (prot_new[6] == o_prot[6]) &
                   (!prot_new[`PROT_HI_DIS] || o_prot[`PROT_HI_DIS]) &
                   (o_prot[`PROT_HI_DIS] || (prot_new[4:3] >= o_prot[4:3])) &
                   (!prot_new[`PROT_LO_DIS] || o_prot[`PROT_LO_DIS]) &
                   (o_prot[`PROT_LO_DIS] || (prot_new[1:0] >= o_prot[1:0]));

  // Protection: open with both ranges disabled (8'hFF) until the reset sequence delivers the stored byte.
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_prot <= `PROT_RESET;
    end else if (i_prot_load) begin
      if (i_prot_load_dbl) begin
        o_prot <= `PROT_DBL_FAULT;
      end else begin
        o_prot <= i_prot_byte;
      end
    end else if ((i_wb_adr == `ADR_PROT) && wr_go && sel_lo && prot_ok) begin
      o_prot <= prot_new;
    end
  end

  // Read data mux, decoded in the wait state; unmapped and reserved read zero.
  always @* begin
    rdat_nxt = 32'h00000000;
    if (i_wb_adr == `ADR_STATUS) begin
      rdat_nxt[`ST_COMPLETE] = complete_r;
      rdat_nxt[`ST_ACCESS_ERROR_FLAG] = access_error_flag_r;
    end else if (i_wb_adr == `ADR_CONFIG) begin
      rdat_nxt[`CFG_IGNORE_SINGLE_FAULT] = ignore_single_fault_r;
    end else if (i_wb_adr == `ADR_PROT) begin
      rdat_nxt[7:0] = o_prot;
    end else if (i_wb_adr == `ADR_RSV1) begin
      rdat_nxt = 32'h00000000;
    end else if (i_wb_adr == `ADR_INDEX) begin
      rdat_nxt[2:0] = index_r;
    end else if (i_wb_adr == `ADR_CCOB) begin
      rdat_nxt[15:0] = ccob_rdata;
    end else if (i_wb_adr == `ADR_FAULT) begin
      rdat_nxt[`FLT_DOUBLE] = df_r;
      rdat_nxt[`FLT_SINGLE] = sf_r;
    end
  end

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_wb_dat <= 32'h00000000;
    end else if (bus_st_nxt == ST_ACK) begin
      o_wb_dat <= i_wb_we ? 32'h00000000 : rdat_nxt;
    end
  end
endmodule

/* wb_host.sv */
// Wishbone classic master standing in for the processor core.
`timescale 1ns/100ps
module wb_host (
  input wire logic i_clk, // Bus clock.
  input wire logic i_ack, // Acknowledge.
  input wire logic [31:0] i_rdat, // Read data.
  output logic o_cyc, // Cycle.
  output logic o_stb, // Strobe.
  output logic o_we, // Write enable.
  output logic [7:0] o_adr, // Byte address.
  output logic [3:0] o_sel, // Byte selects.
  output logic [31:0] o_dat // Write data.
);
  initial {o_cyc, o_stb, o_we, o_adr, o_sel, o_dat} = '0;
  // One access; released address and data show inverted values so stale data is never mistaken.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge i_clk);
    {o_cyc, o_stb, o_we, o_adr, o_sel, o_dat} <= {2'b11, w, a, 4'h3, d};
    do @(posedge i_clk); while (i_ack !== 1'b1);
    q = i_rdat;
    {o_cyc, o_stb} <= 2'b00;
    o_adr <= ~a;
    o_dat <= ~d;
  endtask
endmodule

/* flash_gate_asserts.sv */
// Port checker of the flash command gate.
`timescale 1ns/100ps
module flash_gate_asserts (
  input wire logic i_clk, // Clock.
  input wire logic i_arst_n, // Reset.
  input wire logic i_wb_cyc, // Cycle.
  input wire logic i_wb_stb, // Strobe.
  input wire logic o_wb_ack, // Ack.
  input wire logic i_special_mode_in, // Mode.
  input wire logic i_secure_state_in, // Secured.
  input wire logic i_prot_load, // Load.
  input wire logic [7:0] i_prot_byte, // Byte.
  input wire logic i_prot_load_dbl, // Fault.
  input wire logic i_exec_done, // Done.
  input wire logic o_exec_start, // Start.
  input wire logic [7:0] o_exec_code, // Code.
  input wire logic o_verify_pflash, // Verify.
  input wire logic o_verify_eeprom, // Verify.
  input wire logic o_busy, // Busy.
  input wire logic [7:0] o_prot // Protection.
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  // Which codes may start for m = {secured, special}.
  function automatic logic ok(input logic [7:0] c, input logic [1:0] m);
    case (c)
      8'h01, 8'h02: ok = 1'b1;
      8'h08, 8'h0B: ok = m[0];
      8'h0C: ok = !m[0];
      8'h0E: ok = m == 2'b01;
      8'h03, 8'h04, 8'h06, 8'h07, 8'h09, 8'h0A, 8'h0D, 8'h10, 8'h11, 8'h12: ok = m != 2'b11;
      default: ok = 1'b0;
    endcase
  endfunction
  property p_ack_lat; $rose(i_wb_cyc & i_wb_stb) |-> !o_wb_ack [*2] ##1 o_wb_ack; endproperty
  a_ack_lat: assert property (p_ack_lat) else $error("ack latency wrong");
  property p_ack_one; o_wb_ack |=> !o_wb_ack; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack too long");
  property p_permit; o_exec_start |-> o_busy && ok(o_exec_code, {i_secure_state_in,
    i_special_mode_in}); endproperty
  a_permit: assert property (p_permit) else $error("forbidden start");
  property p_verify; o_busy && o_exec_code == 8'h01 |-> o_verify_pflash && o_verify_eeprom;
  endproperty
  a_verify: assert property (p_verify) else $error("verify not flagged");
  property p_busy; o_busy |=> o_busy != $past(i_exec_done); endproperty
  a_busy: assert property (p_busy) else $error("busy wrong");
  property p_load; i_prot_load && !i_prot_load_dbl |=> o_prot == $past(i_prot_byte); endproperty
  a_load: assert property (p_load) else $error("load wrong");
  property p_dbl; i_prot_load && i_prot_load_dbl |=> o_prot == 8'h7F; endproperty
  a_dbl: assert property (p_dbl) else $error("faulty load wrong");
  property p_closed; !o_prot[7] && !i_prot_load |=> $stable(o_prot); endproperty
  a_closed: assert property (p_closed) else $error("closed protection changed");
  c_start: cover property (o_exec_start);
  c_dbl: cover property (i_prot_load && i_prot_load_dbl);
  c_end: cover property (o_busy && i_exec_done);
endmodule
bind flash_gate flash_gate_asserts u_chk (.i_clk, .i_arst_n, .i_wb_cyc, .i_wb_stb, .o_wb_ack,
  .i_special_mode_in, .i_secure_state_in, .i_prot_load, .i_prot_byte, .i_prot_load_dbl,
  .i_exec_done, .o_exec_start, .o_exec_code, .o_verify_pflash, .o_verify_eeprom, .o_busy,
  .o_prot);

/* tb_top.sv */
// Self-checking bench of the flash command gate.
`timescale 1ns/100ps
module tb_top;
  logic clk = 0, rst_n = 0, spc = 0, sec = 0, rd = 0, es = 0, ed = 0;
  logic pl = 0, pd = 0, done = 0, cyc, stb, we, ack, busy, vp, ve, st;
  logic [7:0] pb = 0, adr, code, prot;
  logic [3:0] sel;
  logic [31:0] wd, rdat, r;
  int error_cnt = 0, total_checks = 0, ticks = 0;
  // Code beside its mode mask; bit {secured, special} set where the code may run.
  logic [11:0] rows [17] = '{12'h01F, 12'h02F, 12'h037, 12'h047, 12'h067, 12'h077, 12'h08A,
    12'h097, 12'h0A7, 12'h0BA, 12'h0C5, 12'h0D7, 12'h0E2, 12'h107, 12'h117, 12'h127, 12'h050};
  wb_host i_bus (.i_clk(clk), .i_ack(ack), .i_rdat(rdat), .o_cyc(cyc), .o_stb(stb), .o_we(we),
    .o_adr(adr), .o_sel(sel), .o_dat(wd));
  flash_gate i_dut (.i_clk(clk), .i_arst_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wd), .o_wb_ack(ack),
    .o_wb_dat(rdat), .i_special_mode_in(spc), .i_secure_state_in(sec), .i_array_read(rd),
    .i_ecc_single(es), .i_ecc_double(ed), .i_prot_load(pl), .i_prot_byte(pb),
    .i_prot_load_dbl(pd), .i_exec_done(done), .o_exec_start(st), .o_exec_code(code),
    .o_verify_pflash(vp), .o_verify_eeprom(ve), .o_busy(busy), .o_prot(prot));
  initial forever #2 clk = ~clk;
  // Cuts a hang short.
  always @(posedge clk) begin
    ticks <= ticks + 1;
    if (ticks == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_bus.xfer(1'b1, a, d, r);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    i_bus.xfer(1'b0, a, 0, r);
    chk(r, e);
  endtask
  task automatic ecc(input logic s, input logic d);
    @(posedge clk) {rd, es, ed} <= {1'b1, s, d};
    @(posedge clk) {rd, es, ed} <= 3'b000;
  endtask
  task automatic load(input logic [7:0] b, input logic d);
    @(posedge clk) {pl, pb, pd} <= {1'b1, b, d};
    @(posedge clk) pl <= 1'b0;
  endtask
  task automatic launch(input logic [7:0] c);
    wr(8'h10, 0);
    wr(8'h14, {16'h0, c, 8'h00});
    wr(8'h00, 32'h80);
  endtask
  task automatic fin;
    @(posedge clk) done <= 1'b1;
    @(posedge clk) done <= 1'b0;
  endtask
  // Main sequence: reset values, command table, then the awkward cases.
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rc(8'h18, 0);
    rc(8'h08, 32'hFF);
    wr(8'h0C, 32'hFF);
    rc(8'h0C, 0);
    rc(8'h1C, 0);
    $display("reset test done");
    foreach (rows[i]) for (int m = 0; m < 4; m++) begin
      @(posedge clk) {sec, spc} <= 2'(m);
      launch(rows[i][11:4]);
      repeat (2) @(posedge clk);
      #1 chk(busy, rows[i][m]);
      chk(vp & ve, rows[i][m] & (rows[i][11:4] == 8'h01));
      if (rows[i][m]) chk(code, rows[i][11:4]);
      rc(8'h00, rows[i][m] ? 0 : 32'hA0);
      if (rows[i][m]) fin();
      else wr(8'h00, 32'h20);
      rc(8'h00, 32'h80);
    end
    $display("table test done");
    @(posedge clk) {sec, spc} <= 2'b00;
    load(8'hE4, 1'b0);
    rc(8'h08, 32'hE4);
    wr(8'h08, 32'hC4);
    rc(8'h08, 32'hC4);
    wr(8'h08, 32'hE4);
    rc(8'h08, 32'hC4);
    chk(prot, 8'hC4);
    load(8'hE4, 1'b1);
    wr(8'h08, 32'hFF);
    rc(8'h08, 32'h7F);
    $display("protection test done");
    ecc(1'b1, 1'b0);
    rc(8'h18, 1);
    wr(8'h18, 1);
    rc(8'h18, 0);
    ecc(1'b1, 1'b1);
    rc(8'h18, 2);
    wr(8'h18, 0);
    rc(8'h18, 2);
    wr(8'h18, 2);
    wr(8'h04, 32'h10);
    ecc(1'b1, 1'b0);
    rc(8'h18, 0);
    wr(8'h04, 0);
    launch(8'h01);
    ecc(1'b0, 1'b0);
    rc(8'h18, 3);
    fin();
    $display("fault test done");
    // Reset after the command has finished, with both flags set: flags and protection return to reset values.
    ecc(1'b0, 1'b1);
    @(posedge clk) rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rc(8'h18, 0);
    rc(8'h08, 32'hFF);
    $display("second reset test done");
    for (int k = 2; k < 6; k++) wr(8'h10, k);
    for (int k = 2; k < 6; k++) begin
      wr(8'h10, k);
      wr(8'h14, {16'h0, 8'(k), ~8'(k)});
    end
    for (int k = 2; k < 6; k++) begin
      wr(8'h10, k);
      rc(8'h14, {16'h0, 8'(k), ~8'(k)});
    end
    $display("command object test done");
    report_and_stop();
  end
endmodule
